/* File: rtl/timer16_pkg.sv */
// Operation
// - compare lowered below count: counter runs on, overflows, restarts.
// - capture skipped when its register is read; capture flag still set.
// - trigger_input_a valid edge comes from ext_int_mode_reg bits 3:2.
// - edge selection writes are accepted while the timer runs.
// - external trigger ignored while a one-shot pulse is running.
// - external trigger stays armed with software one-shot trigger.
// - overflow_flag set when timer_count goes from FFFFH to 0000H.
// - clearing overflow_flag before count reaches 0001H has no effect.
// - reading timer_count never captures into compare_capture_b.
// - input pins ignored while the timer is stopped.
// - both edges on trigger_input_a disable its capture into register a.
// - rewriting compare near or below count may miss that match.
// - compare-mode register ignores capture triggers.
// - pin high after reset gives one edge at first enable only.
// - one-shot clears, starts, output on at first, off at second match.
// - trigger edges selectable: rising, falling or both.
// - writing one to output_control_reg bit 6 is the software trigger.
// - mode field zero stops; any nonzero pattern starts counting.
package timer16_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT  = 8'h00;
  localparam logic [7:0] ADDR_CCA    = 8'h04;
  localparam logic [7:0] ADDR_CCB    = 8'h08;
  localparam logic [7:0] ADDR_MODE   = 8'h0C;
  localparam logic [7:0] ADDR_CAPCTL = 8'h10;
  localparam logic [7:0] ADDR_OUTCTL = 8'h14;
  localparam logic [7:0] ADDR_EXTINT = 8'h18;
  localparam logic [7:0] ADDR_SCS    = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_OVF_BIT   = 0;
  localparam int MODE_LSB       = 1;
  localparam int CAP_A_EN_BIT   = 0;
  localparam int CAP_B_EN_BIT   = 1;
  localparam int CAP_A_SRC_BIT  = 2;
  localparam int OUT_EN_BIT     = 0;
  localparam int OUT_OS_BIT     = 4;
  localparam int OUT_SWTRIG_BIT = 6;
  localparam int EDGE_A_LSB     = 2;
  localparam int EDGE_B_LSB     = 4;
  localparam int STAT_CAPF_BIT  = 0;
  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_STOP      = 3'h0;
  localparam logic [2:0] MODE_CLR_EDGE  = 3'h1;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [1:0] EDGE_FALL      = 2'h0;
  localparam logic [1:0] EDGE_RISE      = 2'h1;
  localparam logic [1:0] EDGE_BOTH      = 2'h3;
  localparam logic [2:0] SCS_PIN_A      = 3'h7;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [15:0] CC_RESET      = 16'h0000;
  typedef enum logic [2:0] {
    OS_IDLE = 3'b001,
    OS_ON   = 3'b010,
    OS_OFF  = 3'b100
  } os_state_t;
endpackage : timer16_pkg

/* File: rtl/timer16_event_counter_core.sv */
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module timer16_event_counter_core (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // timer pins
  input  wire logic        trigger_input_a_i,
  input  wire logic        trigger_input_b_i,
  output logic             timer_output_pin_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] es,
                                    input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (es)
      timer16_pkg::EDGE_FALL: edge_hit = fall;
      timer16_pkg::EDGE_RISE: edge_hit = rise;
      timer16_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default:                edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8],
               sel[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cca_q, cca_d;
  logic [15:0] ccb_q, ccb_d;
  logic [2:0]  mode_q;
  logic [2:0]  capctl_q;
  logic [7:0]  outctl_q;
  logic [7:0]  extint_q;
  logic [2:0]  scs_q;
  logic [7:0]  presc_q;
  logic        ovf_q, ovf_d;
  logic        ovf_hold_q;
  logic        capf_q, capf_d;
  logic        prev_a_q, prev_b_q;
  logic        has_run_q;
  logic        out_q, out_d;
  timer16_pkg::os_state_t os_q, os_d;
  logic        ack_q;
  logic [31:0] rdat_q, rdat_d;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire req      = wb_cyc_i & wb_stb_i;
  wire wr_commit = req & wb_we_i & ack_q;
  wire rd_setup = req & ~wb_we_i & ~ack_q;
  wire wr_cca   = wr_commit & (wb_adr_i == timer16_pkg::ADDR_CCA);
  wire wr_ccb   = wr_commit & (wb_adr_i == timer16_pkg::ADDR_CCB);
  wire wr_mode  = wr_commit & (wb_adr_i == timer16_pkg::ADDR_MODE);
  wire wr_cap   = wr_commit & (wb_adr_i == timer16_pkg::ADDR_CAPCTL);
  wire wr_out   = wr_commit & (wb_adr_i == timer16_pkg::ADDR_OUTCTL);
  wire wr_ext   = wr_commit & (wb_adr_i == timer16_pkg::ADDR_EXTINT);
  wire wr_scs   = wr_commit & (wb_adr_i == timer16_pkg::ADDR_SCS);
  wire wr_stat  = wr_commit & (wb_adr_i == timer16_pkg::ADDR_STATUS);
  wire rd_cca   = rd_setup & (wb_adr_i == timer16_pkg::ADDR_CCA);
  wire rd_ccb   = rd_setup & (wb_adr_i == timer16_pkg::ADDR_CCB);

  // ---------------------------------------------------------------
  // input edges and count clock
  // ---------------------------------------------------------------
  wire running = (mode_q != timer16_pkg::MODE_STOP);
  wire [1:0] es_a = extint_q[timer16_pkg::EDGE_A_LSB +: 2];
  wire [1:0] es_b = extint_q[timer16_pkg::EDGE_B_LSB +: 2];
  // pins count only while running
  wire edge_a = running & edge_hit(es_a, prev_a_q, trigger_input_a_i);
  wire edge_b = running & edge_hit(es_b, prev_b_q, trigger_input_b_i);
  // edge history frozen until first run, tracks pins afterwards
  wire track = running | has_run_q;
  wire [7:0] presc_mask = 8'((9'h001 << scs_q) - 9'h001);
  wire presc_hit = ((presc_q & presc_mask) == presc_mask);
  wire tick = running & ((scs_q == timer16_pkg::SCS_PIN_A) ? edge_a
                                                           : presc_hit);

  // ---------------------------------------------------------------
  // counter control
  // ---------------------------------------------------------------
  wire os_mode  = outctl_q[timer16_pkg::OUT_OS_BIT];
  wire sw_trig  = wr_out & wb_sel_i[0]
                & wb_dat_i[timer16_pkg::OUT_SWTRIG_BIT];
  // ext trigger armed even with sw trigger in use ignored mid-pulse
  wire ext_trig = edge_a & (os_q == timer16_pkg::OS_IDLE);
  wire os_start = running & os_mode & (sw_trig | ext_trig);
  wire clr_edge = (mode_q == timer16_pkg::MODE_CLR_EDGE) & edge_a;
  wire match_a  = tick & (cnt_q == cca_q);
  wire match_b  = tick & (cnt_q == ccb_q);
  // compare below count is simply passed by; counter wraps
  wire clr_match = (mode_q == timer16_pkg::MODE_CLR_MATCH) & match_a;
  wire restart  = os_start | clr_edge;
  wire ovf_evt  = tick & (cnt_q == timer16_pkg::CNT_MAX) & ~restart;

  always_comb begin
    if (!running) begin
      cnt_d = 16'h0000;
    end else if (restart || clr_match) begin
      cnt_d = 16'h0000;
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // clear attempt during the 0000H count is overridden
  wire ovf_clr = wr_mode & wb_sel_i[0]
               & ~wb_dat_i[timer16_pkg::MODE_OVF_BIT];
  assign ovf_d = ovf_evt | ovf_hold_q | (ovf_q & ~ovf_clr);

  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  wire cap_a_en  = capctl_q[timer16_pkg::CAP_A_EN_BIT];
  wire cap_b_en  = capctl_q[timer16_pkg::CAP_B_EN_BIT];
  wire cap_a_pin = capctl_q[timer16_pkg::CAP_A_SRC_BIT];
  // pin a on both edges never captures into register a
  wire trig_cap_a = cap_a_pin ? (edge_a & (es_a != timer16_pkg::EDGE_BOTH))
                              : edge_b;
  wire trig_cap_b = edge_a;
  // compare-mode registers ignore triggers
  wire cap_a_evt = cap_a_en & trig_cap_a;
  wire cap_b_evt = cap_b_en & trig_cap_b;
  // a register being read keeps its value counter reads do nothing
  // to register b
  wire do_cap_a = cap_a_evt & ~rd_cca;
  wire do_cap_b = cap_b_evt & ~rd_ccb;

  always_comb begin
    if (do_cap_a) begin
      cca_d = cnt_q;
    end else if (wr_cca) begin
      cca_d = merge16(cca_q, wb_dat_i, wb_sel_i);
    end else begin
      cca_d = cca_q;
    end
    if (do_cap_b) begin
      ccb_d = cnt_q;
    end else if (wr_ccb) begin
      ccb_d = merge16(ccb_q, wb_dat_i, wb_sel_i);
    end else begin
      ccb_d = ccb_q;
    end
  end

  // flag set on edge even when capture skipped; set wins over clear
  wire capf_clr = wr_stat & wb_sel_i[0]
                & wb_dat_i[timer16_pkg::STAT_CAPF_BIT];
  assign capf_d = cap_a_evt | cap_b_evt | (capf_q & ~capf_clr);

  // ---------------------------------------------------------------
  // one-shot and output
  // ---------------------------------------------------------------
  wire out_en  = outctl_q[timer16_pkg::OUT_EN_BIT];
  wire b_first = (ccb_q <= cca_q);
  wire hit_1st = b_first ? match_b : match_a;
  wire hit_2nd = b_first ? match_a : match_b;

  always_comb begin
    os_d  = os_q;
    out_d = out_q;
    case (os_q)
      timer16_pkg::OS_IDLE: begin
        if (os_start) begin
          os_d  = timer16_pkg::OS_ON;
          out_d = 1'b0;
        end else if (!os_mode && match_a) begin
          out_d = ~out_q;
        end
      end
      timer16_pkg::OS_ON: begin
        if (hit_1st) begin
          os_d  = timer16_pkg::OS_OFF;
          out_d = 1'b1;
        end
      end
      timer16_pkg::OS_OFF: begin
        // counter keeps running after the pulse
        if (hit_2nd) begin
          os_d  = timer16_pkg::OS_IDLE;
          out_d = 1'b0;
        end
      end
      default: begin
        os_d  = timer16_pkg::OS_IDLE;
        out_d = 1'b0;
      end
    endcase
    if (!running || !out_en) begin
      os_d  = timer16_pkg::OS_IDLE;
      out_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (wb_adr_i)
      timer16_pkg::ADDR_COUNT:  rdat_d = {16'h0000, cnt_q};
      timer16_pkg::ADDR_CCA:    rdat_d = {16'h0000, cca_q};
      timer16_pkg::ADDR_CCB:    rdat_d = {16'h0000, ccb_q};
      timer16_pkg::ADDR_MODE:   rdat_d = {28'h0000000, mode_q, ovf_q};
      timer16_pkg::ADDR_CAPCTL: rdat_d = {29'h00000000, capctl_q};
      timer16_pkg::ADDR_OUTCTL: rdat_d = {24'h000000, 1'b0,
                                          outctl_q[6:0] & 7'h3F};
      timer16_pkg::ADDR_EXTINT: rdat_d = {24'h000000, extint_q};
      timer16_pkg::ADDR_SCS:    rdat_d = {29'h00000000, scs_q};
      timer16_pkg::ADDR_STATUS: rdat_d = {28'h0000000, out_q,
                                          os_q != timer16_pkg::OS_IDLE,
                                          running, capf_q};
      default:                  rdat_d = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q   <= timer16_pkg::MODE_STOP;
      capctl_q <= 3'h0;
      outctl_q <= 8'h00;
      extint_q <= 8'h00;
      scs_q    <= 3'h0;
    end else begin
      if (wr_mode && wb_sel_i[0]) begin
        mode_q <= wb_dat_i[timer16_pkg::MODE_LSB +: 3];
      end
      if (wr_cap && wb_sel_i[0]) begin
        capctl_q <= wb_dat_i[2:0];
      end
      if (wr_out && wb_sel_i[0]) begin
        outctl_q <= {1'b0, wb_dat_i[6:0] & 7'h3F};
      end
      // accepted at any time, running or not
      if (wr_ext && wb_sel_i[0]) begin
        extint_q <= wb_dat_i[7:0];
      end
      if (wr_scs && wb_sel_i[0]) begin
        scs_q <= wb_dat_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q      <= 16'h0000;
      cca_q      <= timer16_pkg::CC_RESET;
      ccb_q      <= timer16_pkg::CC_RESET;
      presc_q    <= 8'h00;
      ovf_q      <= 1'b0;
      ovf_hold_q <= 1'b0;
      capf_q     <= 1'b0;
      os_q       <= timer16_pkg::OS_IDLE;
      out_q      <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      cca_q      <= cca_d;
      ccb_q      <= ccb_d;
      presc_q    <= running ? presc_q + 8'h01 : 8'h00;
      ovf_q      <= ovf_d;
      ovf_hold_q <= ovf_evt | (ovf_hold_q & running & ~tick);
      capf_q     <= capf_d;
      os_q       <= os_d;
      out_q      <= out_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_a_q  <= 1'b0;
      prev_b_q  <= 1'b0;
      has_run_q <= 1'b0;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h00000000;
    end else begin
      if (track) begin
        prev_a_q <= trigger_input_a_i;
        prev_b_q <= trigger_input_b_i;
      end
      has_run_q <= has_run_q | running;
      ack_q     <= req & ~ack_q;
      rdat_q    <= rdat_d;
    end
  end

  assign wb_ack_o           = ack_q;
  assign wb_dat_o           = rdat_q;
  assign timer_output_pin_o = out_q;
endmodule : timer16_event_counter_core
`default_nettype wire

/* File: verif/timer16_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module timer16_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        trigger_input_a_i,
  input wire logic        trigger_input_b_i,
  input wire logic        timer_output_pin_o
);
  logic [2:0]  mode_q;
  logic [15:0] cca_q;
  logic        capa_q;
  wire logic   done    = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire logic   wr      = done & wb_we_i;
  wire logic   rd      = done & ~wb_we_i;
  wire logic   at_mode = wb_adr_i == timer16_pkg::ADDR_MODE;
  wire logic   at_cca  = wb_adr_i == timer16_pkg::ADDR_CCA;
  wire logic   at_cap  = wb_adr_i == timer16_pkg::ADDR_CAPCTL;
  wire logic   at_stat = wb_adr_i == timer16_pkg::ADDR_STATUS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // shadow of software-written state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 3'h0;
      cca_q  <= 16'h0000;
      capa_q <= 1'b0;
    end else if (wr) begin
      if (at_mode) mode_q <= wb_dat_i[3:1];
      if (at_cca) cca_q <= wb_dat_i[15:0];
      if (at_cap) capa_q <= wb_dat_i[0];
    end
  end
  a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rst_quiet: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !timer_output_pin_o && wb_dat_o == 32'h0)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (
    rd && wb_adr_i > timer16_pkg::ADDR_STATUS |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_trig_reads0: assert property (rd &&
    wb_adr_i == timer16_pkg::ADDR_OUTCTL |-> !wb_dat_o[6])
    else $error("software trigger bit reads one");
  a_stop_clears: assert property (rd && mode_q == 3'h0 &&
    wb_adr_i == timer16_pkg::ADDR_COUNT |-> wb_dat_o[15:0] == 16'h0)
    else $error("count not zero while stopped");
  a_run_status: assert property (rd && at_stat |->
    wb_dat_o[1] == (mode_q != 3'h0))
    else $error("running bit disagrees with mode");
  a_stop_quiet: assert property (rd && at_stat && mode_q == 3'h0 |->
    !wb_dat_o[2])
    else $error("one-shot active while stopped");
  a_cmp_keeps: assert property (rd && at_cca && !capa_q |->
    wb_dat_o[15:0] == cca_q)
    else $error("compare register changed by capture");
endmodule : timer16_chk
bind timer16_event_counter_core timer16_chk timer16_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .trigger_input_a_i(trigger_input_a_i),
  .trigger_input_b_i(trigger_input_b_i),
  .timer_output_pin_o(timer_output_pin_o));
`default_nettype wire

/* File: verif/trig_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module trig_pin_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // requested levels
  input  wire logic a_lvl_i,
  input  wire logic b_lvl_i,
  // pins
  output logic      trig_a_o,
  output logic      trig_b_o
);
  logic [1:0] hold_q;
  wire logic  chg = (a_lvl_i ^ trig_a_o) | (b_lvl_i ^ trig_b_o);
  // each level stands at least four clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_a_o <= 1'b0;
      trig_b_o <= 1'b0;
      hold_q   <= 2'h0;
    end else if (chg && hold_q == 2'h0) begin
      trig_a_o <= a_lvl_i;
      trig_b_o <= b_lvl_i;
      hold_q   <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
endmodule : trig_pin_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_req = 1'b0, wb_we = 1'b0;
  logic        wb_ack, a_lvl = 1'b0, b_lvl = 1'b0, pin_a, pin_b, out_pin;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rdat;
  int          errors = 0, compares = 0, w;
  logic [15:0] ca [3] = '{16'h0020, 16'h0008, 16'h0020};
  logic [15:0] cb [3] = '{16'h0008, 16'h0020, 16'h0008};
  logic [1:0]  edg [3] = '{timer16_pkg::EDGE_RISE, timer16_pkg::EDGE_FALL,
                           timer16_pkg::EDGE_BOTH};
  timer16_event_counter_core timer16_event_counter_core_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .trigger_input_a_i(pin_a),
    .trigger_input_b_i(pin_b), .timer_output_pin_o(out_pin));
  trig_pin_model trig_pin_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .a_lvl_i(a_lvl), .b_lvl_i(b_lvl), .trig_a_o(pin_a), .trig_b_o(pin_b));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 16);
    chk("ack", 32'h1, {31'h0, wb_ack});
    rdat = wb_rdat;
    wb_req <= 1'b0;
  endtask : xfer
  task pins(input logic a, input logic b);
    @(posedge clk_i);
    a_lvl <= a;
    b_lvl <= b;
    repeat (5) @(posedge clk_i);
  endtask : pins
  task pulse_width(output int pw);
    int n;
    n = 0;
    pw = 0;
    while (out_pin !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    while (out_pin === 1'b1 && pw < 200) begin
      @(posedge clk_i);
      pw++;
    end
  endtask : pulse_width
  task wait_count(input logic [15:0] v);
    int n;
    n = 0;
    do begin
      xfer(timer16_pkg::ADDR_COUNT, 1'b0, 32'h0);
      n++;
    end while (rdat[15:0] !== v && n < 1000);
    chk("count", {16'h0, v}, rdat);
  endtask : wait_count
  initial begin
    repeat (80000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      xfer(8'(i * 4), 1'b0, 32'h0);
      chk("reset value", 32'h0, rdat);
    end
    xfer(8'h24, 1'b1, 32'hFFFF);
    xfer(8'h24, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rdat);
    pins(1'b1, 1'b0);
    xfer(timer16_pkg::ADDR_CAPCTL, 1'b1, 32'h2);
    xfer(timer16_pkg::ADDR_EXTINT, 1'b1, 32'h4);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    xfer(timer16_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("first enable edge", 32'h3, rdat);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_STATUS, 1'b1, 32'h1);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    xfer(timer16_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("re-enable no edge", 32'h2, rdat);
    xfer(timer16_pkg::ADDR_CAPCTL, 1'b1, 32'h0);
    pins(1'b0, 1'b0);
    xfer(timer16_pkg::ADDR_SCS, 1'b1, 32'h7);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    repeat (2) begin
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
    end
    xfer(timer16_pkg::ADDR_COUNT, 1'b0, 32'h0);
    chk("event count", 32'h2, rdat);
    xfer(timer16_pkg::ADDR_SCS, 1'b1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
      xfer(timer16_pkg::ADDR_EXTINT, 1'b1, {28'h0, edg[i], 2'h0});
      xfer(timer16_pkg::ADDR_CCA, 1'b1, {16'h0, ca[i]});
      xfer(timer16_pkg::ADDR_CCB, 1'b1, {16'h0, cb[i]});
      xfer(timer16_pkg::ADDR_OUTCTL, 1'b1, 32'h11);
      xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
      fork
        pulse_width(w);
        repeat (2) begin
          pins(1'b1, 1'b0);
          pins(1'b0, 1'b0);
        end
      join
      chk("pin pulse width", 32'd24, 32'(w));
    end
    xfer(timer16_pkg::ADDR_OUTCTL, 1'b1, 32'h51);
    pulse_width(w);
    chk("soft pulse width", 32'd24, 32'(w));
    xfer(timer16_pkg::ADDR_OUTCTL, 1'b0, 32'h0);
    chk("output control", 32'h11, rdat);
    xfer(timer16_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status after pulse", 32'h2, rdat);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_OUTCTL, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_CAPCTL, 1'b1, 32'h2);
    xfer(timer16_pkg::ADDR_EXTINT, 1'b1, 32'h4);
    xfer(timer16_pkg::ADDR_CCA, 1'b1, 32'h1234);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b0);
    xfer(timer16_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("stopped status", 32'h0, rdat);
    chk("stopped output", 32'h0, {31'h0, out_pin});
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b0);
    xfer(timer16_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("capture flag", 32'h3, rdat);
    xfer(timer16_pkg::ADDR_CCA, 1'b0, 32'h0);
    chk("compare kept", 32'h1234, rdat);
    xfer(timer16_pkg::ADDR_STATUS, 1'b1, 32'h1);
    xfer(timer16_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("flag cleared", 32'h2, rdat);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_CAPCTL, 1'b1, 32'h5);
    xfer(timer16_pkg::ADDR_EXTINT, 1'b1, 32'hC);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    xfer(timer16_pkg::ADDR_CCA, 1'b0, 32'h0);
    chk("both edges no capture", 32'h1234, rdat);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_CAPCTL, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_CCA, 1'b1, 32'h20);
    xfer(timer16_pkg::ADDR_OUTCTL, 1'b1, 32'h1);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h4);
    pulse_width(w);
    chk("match half period", 32'd33, 32'(w));
    xfer(timer16_pkg::ADDR_OUTCTL, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h0);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    xfer(timer16_pkg::ADDR_MODE, 1'b0, 32'h0);
    chk("no early overflow", 32'h8, rdat);
    repeat (65500) @(posedge clk_i);
    xfer(timer16_pkg::ADDR_SCS, 1'b1, 32'h5);
    wait_count(16'h0000);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    xfer(timer16_pkg::ADDR_MODE, 1'b0, 32'h0);
    chk("clear at zero", 32'h9, rdat);
    wait_count(16'h0001);
    xfer(timer16_pkg::ADDR_MODE, 1'b1, 32'h8);
    xfer(timer16_pkg::ADDR_MODE, 1'b0, 32'h0);
    chk("clear at one", 32'h8, rdat);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
